// ==== logic/fsf_defs.vh ====
`ifndef FSF_DEFS_VH
`define FSF_DEFS_VH

// ==========================================================================
// Register map of the plain register port (word indices).
`define FSF_REG_AE_OFF    4'h0
`define FSF_REG_AF_OFF    4'h1
`define FSF_REG_STATUS    4'h2
`define FSF_REG_RLEVEL    4'h3
`define FSF_REG_IRQ_STAT  4'h4
`define FSF_REG_IRQ_MASK  4'h5

// ==========================================================================
// Reset values and field layouts.
`define FSF_OFF_DEFAULT   14'h0007
`define FSF_IRQ_W         4
`define FSF_IRQ_FULL      0
`define FSF_IRQ_EMPTY     1
`define FSF_IRQ_WR_DROP   2
`define FSF_IRQ_RD_DROP   3
`define FSF_STAT_EMPTY_N  0
`define FSF_STAT_AE_N     1
`define FSF_STAT_AF_N     2
`define FSF_STAT_FULL_N   3
`define FSF_STAT_MODE     4

// ==========================================================================
// Pin synchroniser layout and idle value.
`define FSF_PIN_W         14
`define FSF_PIN_RESET_N   13
`define FSF_PIN_WEN_A_N   12
`define FSF_PIN_WEN_B     11
`define FSF_PIN_REN_A_N   10
`define FSF_PIN_REN_B_N   9
`define FSF_PIN_IDLE      14'h3600

`endif

// ==== logic/fsf_fifo_flags.v ====
// Summary of operation
// RULE1: Empty flag low when no words; blocks reads.
// RULE2: Empty flag updates on read side clock.
// RULE3: Almost-empty low within programmed offset of empty.
// RULE4: Almost-empty offset defaults to seven after reset.
// RULE5: Almost-empty flag updates on read side clock.
// RULE6: Almost-full low within programmed offset of full.
// RULE7: Almost-full offset defaults to seven after reset.
// RULE8: Almost-full flag updates on write side clock.
// RULE9: Full flag low when full; ignores writes.
// RULE10: Full flag updates on write side clock.
// RULE11: Reset clears pointers and forces flag levels.
// RULE12: Read when both read enables low, not empty.
// RULE13: Write when write enables asserted, not full.
// RULE14: Second write pin sampled at reset selects role.
// RULE15: Depth is a parameter from the listed sizes.
// RULE16: Crossing pointers are Gray coded and synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "fsf_defs.vh"

module fsf_fifo_flags #(
  parameter integer DEPTH = 64
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        reset_n,
  input  wire        write_enable_a_n,
  input  wire        write_enable_b_or_load,
  input  wire        read_enable_a_n,
  input  wire        read_enable_b_n,
  input  wire [8:0]  data_in,
  output reg  [8:0]  data_out_q,
  output reg         empty_flag_n,
  output reg         almost_empty_n,
  output reg         almost_full_n,
  output reg         full_flag_n,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata_q,
  output wire        irq
);

  localparam integer AW = $clog2(DEPTH);
  localparam integer W  = AW + 1;
  localparam [13:0]  OFF_DEF = `FSF_OFF_DEFAULT;
  localparam [W:0]   DEPTH_X = DEPTH[W:0];

  // ========================================================================
  // Helpers.
  function [W-1:0] bin2gray;
    input [W-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [W-1:0] gray2bin;
    input [W-1:0] g;
    integer i;
    begin
      gray2bin[W-1] = g[W-1];
      for (i = W - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // ========================================================================
  // Pin synchronisers. Data travels with its enables so both stay aligned.
  reg  [`FSF_PIN_W-1:0] pin_s1_q;
  reg  [`FSF_PIN_W-1:0] pin_s2_q;
  wire [`FSF_PIN_W-1:0] pin_raw = {reset_n, write_enable_a_n, write_enable_b_or_load,
                                   read_enable_a_n, read_enable_b_n, data_in};

  always @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= `FSF_PIN_IDLE;
      pin_s2_q <= `FSF_PIN_IDLE;
    end else if (clk_en) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire fifo_rst = sys_rst | ~pin_s2_q[`FSF_PIN_RESET_N];

  // ========================================================================
  // Port role strap. It is caught by the clock while the reset pin is low.
  reg two_wen_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      two_wen_q <= 1'b1;
    end else if (clk_en && !pin_s2_q[`FSF_PIN_RESET_N]) begin
      two_wen_q <= pin_s2_q[`FSF_PIN_WEN_B]; // RULE14
    end
  end

  // In single-enable mode the second pin no longer gates writes.
  wire wr_req = !pin_s2_q[`FSF_PIN_WEN_A_N] &&
                (!two_wen_q || pin_s2_q[`FSF_PIN_WEN_B]); // RULE14
  wire rd_req = !pin_s2_q[`FSF_PIN_REN_A_N] && !pin_s2_q[`FSF_PIN_REN_B_N];
  wire wr_ok  = wr_req && full_flag_n; // RULE13 RULE9
  wire rd_ok  = rd_req && empty_flag_n; // RULE12 RULE1

  // ========================================================================
  // Storage and pointers.
  reg  [8:0]   mem_q [0:DEPTH-1];
  reg  [W-1:0] wbin_q;
  reg  [W-1:0] rbin_q;
  reg  [W-1:0] wgray_q;
  reg  [W-1:0] rgray_q;
  reg  [W-1:0] wgray_s1_q;
  reg  [W-1:0] wgray_s2_q;
  reg  [W-1:0] rgray_s1_q;
  reg  [W-1:0] rgray_s2_q;
  wire [W-1:0] wbin_d = wr_ok ? wbin_q + {{(W-1){1'b0}}, 1'b1} : wbin_q;
  wire [W-1:0] rbin_d = rd_ok ? rbin_q + {{(W-1){1'b0}}, 1'b1} : rbin_q;

  always @(posedge clk) begin
    if (clk_en && wr_ok) begin
      mem_q[wbin_q[AW-1:0]] <= pin_s2_q[8:0];
    end
  end

  always @(posedge clk) begin
    if (fifo_rst) begin
      wbin_q     <= {W{1'b0}}; // RULE11
      rbin_q     <= {W{1'b0}}; // RULE11
      wgray_q    <= {W{1'b0}};
      rgray_q    <= {W{1'b0}};
      wgray_s1_q <= {W{1'b0}};
      wgray_s2_q <= {W{1'b0}};
      rgray_s1_q <= {W{1'b0}};
      rgray_s2_q <= {W{1'b0}};
      data_out_q <= 9'h000;
    end else if (clk_en) begin
      wbin_q     <= wbin_d;
      rbin_q     <= rbin_d;
      wgray_q    <= bin2gray(wbin_d); // RULE16
      rgray_q    <= bin2gray(rbin_d); // RULE16
      wgray_s1_q <= wgray_q; // RULE16
      wgray_s2_q <= wgray_s1_q;
      rgray_s1_q <= rgray_q; // RULE16
      rgray_s2_q <= rgray_s1_q;
      if (rd_ok) begin
        data_out_q <= mem_q[rbin_q[AW-1:0]]; // RULE12
      end
    end
  end

  // ========================================================================
  // Flags. Each side sees the other pointer late, so its flags are
  // pessimistic: they may report fuller or emptier, never less so.
  reg  [W-1:0] ae_off_q;
  reg  [W-1:0] af_off_q;
  wire [W-1:0] wbin_rs = gray2bin(wgray_s2_q); // RULE16
  wire [W-1:0] rbin_ws = gray2bin(rgray_s2_q); // RULE16
  wire [W-1:0] rlevel  = wbin_rs - rbin_d;
  wire [W-1:0] wlevel  = wbin_d - rbin_ws;
  wire [W:0]   wsum    = {1'b0, wlevel} + {1'b0, af_off_q};

  always @(posedge clk) begin
    if (fifo_rst) begin
      empty_flag_n   <= 1'b0; // RULE11
      almost_empty_n <= 1'b0; // RULE11
      almost_full_n  <= 1'b1; // RULE11
      full_flag_n    <= 1'b1; // RULE11
    end else if (clk_en) begin
      empty_flag_n   <= (rlevel != {W{1'b0}}); // RULE1 RULE2
      almost_empty_n <= (rlevel > ae_off_q); // RULE3 RULE5
      almost_full_n  <= (wsum < DEPTH_X); // RULE6 RULE8 RULE15
      full_flag_n    <= ({1'b0, wlevel} != DEPTH_X); // RULE9 RULE10 RULE15
    end
  end

  // ========================================================================
  // Register port and interrupts.
  reg  [`FSF_IRQ_W-1:0] irq_stat_q;
  reg  [`FSF_IRQ_W-1:0] irq_mask_q;
  reg                   full_n_prev_q;
  reg                   empty_n_prev_q;
  wire [`FSF_IRQ_W-1:0] irq_ev;
  wire [`FSF_IRQ_W-1:0] irq_clr;

  assign irq_ev[`FSF_IRQ_FULL]    = full_n_prev_q && !full_flag_n;
  assign irq_ev[`FSF_IRQ_EMPTY]   = empty_n_prev_q && !empty_flag_n;
  assign irq_ev[`FSF_IRQ_WR_DROP] = wr_req && !full_flag_n;
  assign irq_ev[`FSF_IRQ_RD_DROP] = rd_req && !empty_flag_n;
  assign irq_clr = (reg_wr && reg_addr == `FSF_REG_IRQ_STAT) ?
                   reg_wdata[`FSF_IRQ_W-1:0] : {`FSF_IRQ_W{1'b0}};
  assign irq = |(irq_stat_q & irq_mask_q);

  always @(posedge clk) begin
    if (fifo_rst) begin
      ae_off_q <= OFF_DEF[W-1:0]; // RULE4
      af_off_q <= OFF_DEF[W-1:0]; // RULE7
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `FSF_REG_AE_OFF) begin
        ae_off_q <= reg_wdata[W-1:0];
      end
      if (reg_addr == `FSF_REG_AF_OFF) begin
        af_off_q <= reg_wdata[W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q     <= {`FSF_IRQ_W{1'b0}};
      irq_mask_q     <= {`FSF_IRQ_W{1'b0}};
      full_n_prev_q  <= 1'b1;
      empty_n_prev_q <= 1'b0;
      reg_rdata_q    <= 16'h0000;
    end else if (clk_en) begin
      full_n_prev_q  <= full_flag_n;
      empty_n_prev_q <= empty_flag_n;
      // A new event in the clearing cycle keeps its bit set.
      irq_stat_q     <= (irq_stat_q & ~irq_clr) | irq_ev;
      if (reg_wr && reg_addr == `FSF_REG_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[`FSF_IRQ_W-1:0];
      end
      reg_rdata_q <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `FSF_REG_AE_OFF:   reg_rdata_q[W-1:0] <= ae_off_q;
          `FSF_REG_AF_OFF:   reg_rdata_q[W-1:0] <= af_off_q;
          `FSF_REG_STATUS: begin
            reg_rdata_q[`FSF_STAT_EMPTY_N] <= empty_flag_n;
            reg_rdata_q[`FSF_STAT_AE_N]    <= almost_empty_n;
            reg_rdata_q[`FSF_STAT_AF_N]    <= almost_full_n;
            reg_rdata_q[`FSF_STAT_FULL_N]  <= full_flag_n;
            reg_rdata_q[`FSF_STAT_MODE]    <= two_wen_q;
          end
          `FSF_REG_RLEVEL:   reg_rdata_q[W-1:0] <= wbin_q - rbin_q;
          `FSF_REG_IRQ_STAT: reg_rdata_q[`FSF_IRQ_W-1:0] <= irq_stat_q;
          `FSF_REG_IRQ_MASK: reg_rdata_q[`FSF_IRQ_W-1:0] <= irq_mask_q;
          default:           reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/fsf_flags_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsf_flags_checker #(
  parameter integer DEPTH = 64
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reset_n,
  input wire logic        write_enable_a_n,
  input wire logic        read_enable_a_n,
  input wire logic [8:0]  data_out_q,
  input wire logic        empty_flag_n,
  input wire logic        almost_empty_n,
  input wire logic        almost_full_n,
  input wire logic        full_flag_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_q
);
  default clocking cb @(posedge clk); endclocking
  // The reset pin clears the read data, so checks rest while it is low.
  default disable iff (sys_rst || !reset_n);
  full_af_a: assert property (!full_flag_n |-> !almost_full_n)
    else $error("full without almost full");
  empty_ae_a: assert property (!empty_flag_n |-> !almost_empty_n)
    else $error("empty without almost empty");
  never_both_a: assert property (full_flag_n || empty_flag_n)
    else $error("full and empty together");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside its cycle");
  dout_hold_a: assert property ($changed(data_out_q) |-> $past(empty_flag_n))
    else $error("data moved while empty");
  fill_cause_a: assert property ($fell(full_flag_n) |->
    !($past(write_enable_a_n, 2) && $past(write_enable_a_n, 3) && $past(write_enable_a_n, 4)))
    else $error("full without a write");
  drain_cause_a: assert property ($fell(empty_flag_n) |->
    !($past(read_enable_a_n, 2) && $past(read_enable_a_n, 3) && $past(read_enable_a_n, 4)))
    else $error("empty without a read");
  status_bits_a: assert property ((reg_rd && reg_addr == 4'h2) ##1
    $stable({full_flag_n, almost_full_n, almost_empty_n, empty_flag_n}) |->
    reg_rdata_q[3:0] == {full_flag_n, almost_full_n, almost_empty_n, empty_flag_n})
    else $error("status read mismatch");
endmodule
bind fsf_fifo_flags fsf_flags_checker #(.DEPTH(DEPTH)) i_fsf_flags_checker (
  .clk(clk), .sys_rst(sys_rst), .reset_n(reset_n), .write_enable_a_n(write_enable_a_n),
  .read_enable_a_n(read_enable_a_n), .data_out_q(data_out_q), .empty_flag_n(empty_flag_n),
  .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .full_flag_n(full_flag_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
`default_nettype wire

// ==== test/fsf_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsf_far_end (
  input  wire logic       clk,
  input  wire logic       wr_go,
  input  wire logic       rd_go,
  input  wire logic       wen_b,
  input  wire logic [8:0] wdata,
  output var  logic       write_enable_a_n,
  output var  logic       write_enable_b_or_load,
  output var  logic       read_enable_a_n,
  output var  logic       read_enable_b_n,
  output var  logic [8:0] data_in
);
  // The second enable starts high, matching the two-enable mode that the system reset loads.
  initial begin
    write_enable_a_n = 1'b1;
    write_enable_b_or_load = 1'b1;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    data_in = 9'h000;
  end
  // Idle data toggles so a stale word is never mistaken for a fresh one.
  always @(posedge clk) begin
    write_enable_a_n <= !wr_go;
    read_enable_a_n <= !rd_go;
    read_enable_b_n <= !rd_go;
    write_enable_b_or_load <= wen_b;
    data_in <= wr_go ? wdata : ~data_in;
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, sys_rst, wr_go, rd_go, reg_wr, reg_rd, wea_n, web, rea_n, reb_n;
  logic rst_pin_n, wen_b;
  logic [8:0] wdata, din, last;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  wire logic [8:0] dout;
  wire logic [15:0] rdata;
  wire logic ef, aef, aff, ff, irq;
  integer failures, checks_done, seed, aeo, i;
  logic [8:0] q[$];
  fsf_fifo_flags #(.DEPTH(64)) i_fsf_fifo_flags (.clk(clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .reset_n(rst_pin_n), .write_enable_a_n(wea_n), .write_enable_b_or_load(web),
    .read_enable_a_n(rea_n), .read_enable_b_n(reb_n), .data_in(din), .data_out_q(dout),
    .empty_flag_n(ef), .almost_empty_n(aef), .almost_full_n(aff), .full_flag_n(ff),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdata), .irq(irq));
  fsf_far_end i_fsf_far_end (.clk(clk), .wr_go(wr_go), .rd_go(rd_go), .wen_b(wen_b),
    .wdata(wdata),
    .write_enable_a_n(wea_n), .write_enable_b_or_load(web), .read_enable_a_n(rea_n),
    .read_enable_b_n(reb_n), .data_in(din));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  function automatic logic [15:0] fexp(int l);
    return {12'h000, l < 64, l < 57, l > aeo, l > 0};
  endfunction
  // Each word is let settle, since flags lag the far pointer by a few edges.
  task step(input bit w);
    @(posedge clk);
    if (w) wdata <= 9'($random(seed));
    wr_go <= w;
    rd_go <= !w;
    @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    if (w && q.size() < 64) q.push_back(wdata);
    if (!w && q.size() > 0) last = q.pop_front();
    repeat (8) @(posedge clk);
    #1 chk({12'h000, ff, aff, aef, ef}, fexp(q.size()));
    if (!w) chk({7'h00, dout}, {7'h00, last});
  endtask
  initial begin
    seed = 32'he43e;
    {failures, checks_done, aeo} = {32'd0, 32'd0, 32'd7};
    {sys_rst, reg_wr, reg_rd, wr_go, rd_go} = 5'b10000;
    {rst_pin_n, wen_b} = 2'b11;
    {reg_addr, reg_wdata, wdata, last} = 38'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk({12'h000, ff, aff, aef, ef}, 16'h000c);
    rreg(4'h0, 16'h0007);
    rreg(4'h1, 16'h0007);
    rreg(4'h9, 16'h0000);
    wreg(4'h5, 16'h000f);
    $display("reset test done");
    for (i = 0; i < 66; i++) step(1'b1);
    rreg(4'h3, 16'h0040);
    rreg(4'h2, 16'h0013);
    chk({15'h0, irq}, 16'h0001);
    wreg(4'h4, 16'h000f);
    #1 chk({15'h0, irq}, 16'h0000);
    wreg(4'h0, 16'h0003);
    aeo = 3;
    $display("fill test done");
    for (i = 0; i < 66; i++) step(1'b0);
    rreg(4'h3, 16'h0000);
    $display("drain test done");
    // Reset by the pin with the second enable low straps the single-enable mode.
    wen_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    q.delete();
    aeo = 7;
    rreg(4'h2, 16'h000c);
    rreg(4'h0, 16'h0007);
    step(1'b1);
    rreg(4'h3, 16'h0001);
    $display("pin reset test done");
    conclude;
  end
endmodule
`default_nettype wire
